//--- rtl/mps_cfg.svh
// constants of the motor parameter store
`ifndef MPS_CFG_SVH
`define MPS_CFG_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define MPS_OP_WORDS    7'h40
`define MPS_ALL_WORDS   7'h50
`define MPS_LAST_WORD   7'h4f
`define MPS_PAR_CNT     16

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define MPS_PAR_BASE    8'h40
`define MPS_EFF_BASE    8'h50
`define MPS_EFF_END     8'h60
`define MPS_CTRL_ADDR   8'h60
`define MPS_STAT_ADDR   8'h61
`define MPS_PEND_ADDR   8'h62
`define MPS_CTRL_COMMIT 0
`define MPS_CTRL_CONFIG 1
`define MPS_CTRL_ANALOG 2
`define MPS_STAT_BUSY   0
`define MPS_STAT_REJ    1
`define MPS_STAT_RUN    2

// ----------------------------------------------------------------
// operation data fields and ranges
// ----------------------------------------------------------------
`define MPS_F_SPEED     2'h0
`define MPS_F_ACCEL     2'h1
`define MPS_F_DECEL     2'h2
`define MPS_F_TORQUE    2'h3
`define MPS_SPD_MAX     16'h0fa0
`define MPS_SPD_MIN_AN  16'h0064
`define MPS_SPD_MIN_DG  16'h0050
`define MPS_RAMP_MIN    16'h0002
`define MPS_RAMP_MAX    16'h0096
`define MPS_TRQ_MAX     16'h00c8
`define MPS_RATED_SPD   16'h0bb8

// ----------------------------------------------------------------
// initial values
// ----------------------------------------------------------------
`define MPS_DEF_SPEED   16'h0000
`define MPS_DEF_RAMP    16'h0005
`define MPS_DEF_TRQ     16'h00c8
`define MPS_DEF_PARAM   16'h0000

// ----------------------------------------------------------------
// update classes, two bits per parameter
// ----------------------------------------------------------------
`define MPS_CLS_A       2'h0
`define MPS_CLS_B       2'h1
`define MPS_CLS_C       2'h2
`define MPS_CLS_D       2'h3
`define MPS_PAR_CLASS   32'hffaa5500

`endif

//--- rtl/mps_pkg.sv
// types of the motor parameter store
package mps_pkg;
    typedef logic [15:0] mps_word_t;
    typedef logic [7:0]  mps_addr_t;
    typedef logic [6:0]  mps_idx_t;
    typedef logic [1:0]  mps_class_t;
    typedef enum logic [3:0] {
        MPS_ST_LOAD   = 4'h1,
        MPS_ST_SETUP  = 4'h2,
        MPS_ST_IDLE   = 4'h4,
        MPS_ST_COMMIT = 4'h8
    } mps_state_t;
endpackage

//--- rtl/mps_nv_store.sv
// non-volatile parameter image, kept across reset
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_nv_store (
    input  wire logic          clk,
    input  wire logic          factory_init,
    input  wire logic          we,
    input  wire mps_pkg::mps_idx_t  waddr,
    input  wire mps_pkg::mps_word_t wdata,
    input  wire mps_pkg::mps_idx_t  raddr,
    output mps_pkg::mps_word_t      rdata
);
    import mps_pkg::*;

    mps_word_t nv_q [80];

    function automatic mps_word_t def_word(input int i);
        logic [1:0] f;
        f = i[1:0];
        if (i >= `MPS_OP_WORDS)
            def_word = `MPS_DEF_PARAM;
        else if (f == `MPS_F_SPEED)
            def_word = `MPS_DEF_SPEED;
        else if (f == `MPS_F_TORQUE)
            def_word = `MPS_DEF_TRQ;
        else
            def_word = `MPS_DEF_RAMP;
    endfunction

    // no reset: contents survive loss of the working supply
    always_ff @(posedge clk) begin
        if (factory_init) begin
            for (int i = 0; i < `MPS_ALL_WORDS; i++) begin
                nv_q[i] <= def_word(i);
            end
        end else if (we) begin
            nv_q[waddr] <= wdata;
        end
    end

    assign rdata = nv_q[raddr];
endmodule // mps_nv_store

//--- rtl/mps_opdata_sel.sv
// registered view of the selected operation-data set
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_opdata_sel (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              analog_mode,
    input  wire mps_pkg::mps_word_t speed,
    input  wire mps_pkg::mps_word_t accel,
    input  wire mps_pkg::mps_word_t decel,
    input  wire mps_pkg::mps_word_t torque,
    output mps_pkg::mps_word_t      op_speed,
    output mps_pkg::mps_word_t      op_accel,
    output mps_pkg::mps_word_t      op_decel,
    output mps_pkg::mps_word_t      op_torque,
    output mps_pkg::mps_word_t      op_ramp_ref
);
    import mps_pkg::*;

    wire mps_word_t ramp_ref_d;

    // ramp times refer to rated speed when analog, set speed when digital
    assign ramp_ref_d = analog_mode ? `MPS_RATED_SPD : speed;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op_speed    <= `MPS_DEF_SPEED;
            op_accel    <= `MPS_DEF_RAMP;
            op_decel    <= `MPS_DEF_RAMP;
            op_torque   <= `MPS_DEF_TRQ;
            op_ramp_ref <= `MPS_DEF_SPEED;
        end else begin
            op_speed    <= speed;
            op_accel    <= accel;
            op_decel    <= decel;
            op_torque   <= torque;
            op_ramp_ref <= ramp_ref_d;
        end
    end
endmodule // mps_opdata_sel

//--- rtl/mps_param_store.sv
// motor parameter store: working copy, non-volatile image, update classes
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_param_store (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire mps_pkg::mps_addr_t  addr,
    input  wire mps_pkg::mps_word_t  wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output mps_pkg::mps_word_t       rdata,
    input  wire logic               motor_running,
    input  wire logic               nv_factory_init,
    input  wire logic [3:0]         op_select,
    output logic                    internal_processing_flag,
    output mps_pkg::mps_word_t       op_speed,
    output mps_pkg::mps_word_t       op_accel,
    output mps_pkg::mps_word_t       op_decel,
    output mps_pkg::mps_word_t       op_torque,
    output mps_pkg::mps_word_t       op_ramp_ref,
    output logic [255:0]            param_eff,
    output logic [15:0]             param_pending
);
    import mps_pkg::*;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic mps_class_t par_class(input int p);
        logic [31:0] tbl;
        tbl = `MPS_PAR_CLASS;
        par_class = tbl[2*p +: 2];
    endfunction

    function automatic logic op_ok(input logic [1:0] f, input mps_word_t d,
                                   input logic analog);
        mps_word_t smin;
        smin = analog ? `MPS_SPD_MIN_AN : `MPS_SPD_MIN_DG;
        case (f)
            `MPS_F_SPEED:  op_ok = (d >= smin) && (d <= `MPS_SPD_MAX);
            `MPS_F_TORQUE: op_ok = (d <= `MPS_TRQ_MAX);
            default:       op_ok = (d >= `MPS_RAMP_MIN) && (d <= `MPS_RAMP_MAX);
        endcase
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    mps_state_t state_q;
    mps_idx_t   cnt_q;
    mps_word_t  ram_q [80];
    mps_word_t  eff_q [`MPS_PAR_CNT];
    logic [15:0] pend_q;
    logic       analog_q;
    logic       rej_q;
    logic       init_s1_q;
    logic       init_s2_q;
    mps_word_t  rdata_q;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic      idle       = (state_q == MPS_ST_IDLE);
    wire logic      in_ram     = (addr < {1'b0, `MPS_ALL_WORDS});
    wire logic      in_op      = (addr < {1'b0, `MPS_OP_WORDS});
    wire logic      in_par     = in_ram && !in_op;
    wire logic      in_eff     = (addr >= `MPS_EFF_BASE) && (addr < `MPS_EFF_END);
    wire logic      is_ctrl    = (addr == `MPS_CTRL_ADDR);
    wire logic      is_stat    = (addr == `MPS_STAT_ADDR);
    wire logic      is_pend    = (addr == `MPS_PEND_ADDR);
    wire mps_idx_t  ridx       = addr[6:0];
    wire logic      data_ok    = in_op ? op_ok(addr[1:0], wdata, analog_q) : 1'b1;
    wire logic      host_wr    = wr && in_ram && idle && data_ok;
    wire logic      host_rej   = wr && in_ram && !(idle && data_ok);
    wire logic      ctrl_wr    = wr && is_ctrl;
    wire logic      commit_req = ctrl_wr && idle && wdata[`MPS_CTRL_COMMIT];
    wire logic      cfg_pulse  = ctrl_wr && idle && wdata[`MPS_CTRL_CONFIG];
    wire logic      rej_clr    = wr && is_stat && wdata[`MPS_STAT_REJ];
    wire logic      last_word  = (cnt_q == `MPS_LAST_WORD);
    wire logic      loading    = (state_q == MPS_ST_LOAD);
    wire logic      setup      = (state_q == MPS_ST_SETUP);
    wire logic      committing = (state_q == MPS_ST_COMMIT);
    wire mps_word_t nv_rdata;

    // working-copy write port: power-up load or host write
    wire logic      ram_we    = loading || host_wr;
    wire mps_idx_t  ram_waddr = loading ? cnt_q : ridx;
    wire mps_word_t ram_wdata = loading ? nv_rdata : wdata;

    // selected operation-data set
    wire mps_idx_t  sel_base  = {1'b0, op_select, 2'h0};

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= MPS_ST_LOAD;
            cnt_q   <= 7'h00;
        end else begin
            case (state_q)
                MPS_ST_LOAD: begin
                    cnt_q <= last_word ? 7'h00 : cnt_q + 7'h01;
                    if (last_word) begin
                        state_q <= MPS_ST_SETUP;
                    end
                end
                MPS_ST_SETUP: begin
                    state_q <= MPS_ST_IDLE;
                end
                MPS_ST_IDLE: begin
                    if (commit_req) begin
                        state_q <= MPS_ST_COMMIT;
                    end
                end
                MPS_ST_COMMIT: begin
                    cnt_q <= last_word ? 7'h00 : cnt_q + 7'h01;
                    if (last_word) begin
                        state_q <= MPS_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= MPS_ST_LOAD;
                    cnt_q   <= 7'h00;
                end
            endcase
        end
    end

    // busy while loading, setting up or committing
    assign internal_processing_flag = !idle;

    // ----------------------------------------------------------------
    // non-volatile image
    // ----------------------------------------------------------------
    mps_nv_store u_nv (
        .clk          (clk),
        .factory_init (init_s2_q),
        .we           (committing),
        .waddr        (cnt_q),
        .wdata        (ram_q[cnt_q]),
        .raddr        (cnt_q),
        .rdata        (nv_rdata)
    );

    // factory-initialise pin synchroniser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            init_s1_q <= 1'b0;
            init_s2_q <= 1'b0;
        end else begin
            init_s1_q <= nv_factory_init;
            init_s2_q <= init_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // working copy
    // ----------------------------------------------------------------
    // cleared by reset: nothing survives loss of supply here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < `MPS_ALL_WORDS; i++) begin
                ram_q[i] <= `MPS_DEF_PARAM;
            end
        end else if (ram_we) begin
            ram_q[ram_waddr] <= ram_wdata;
        end
    end

    // ----------------------------------------------------------------
    // effective parameters per update class
    // ----------------------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < `MPS_PAR_CNT; gp++) begin : g_par
            localparam mps_class_t CLS = par_class(gp);
            wire logic hit  = host_wr && in_par && (ridx[3:0] == 4'(gp));
            wire logic trig = (CLS == `MPS_CLS_B) ? !motor_running :
                              (CLS == `MPS_CLS_C) ? cfg_pulse :
                              1'b0;
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    eff_q[gp]  <= `MPS_DEF_PARAM;
                    pend_q[gp] <= 1'b0;
                end else if (setup) begin
                    eff_q[gp]  <= ram_q[`MPS_OP_WORDS + 7'(gp)];
                    pend_q[gp] <= 1'b0;
                end else if (hit && CLS == `MPS_CLS_A) begin
                    eff_q[gp]  <= wdata;
                end else if (hit) begin
                    pend_q[gp] <= 1'b1;
                end else if (pend_q[gp] && trig) begin
                    eff_q[gp]  <= ram_q[`MPS_OP_WORDS + 7'(gp)];
                    pend_q[gp] <= 1'b0;
                end
            end
            assign param_eff[16*gp +: 16] = eff_q[gp];
        end
    endgenerate

    assign param_pending = pend_q;

    // ----------------------------------------------------------------
    // control and status
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            analog_q <= 1'b0;
            rej_q    <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                analog_q <= wdata[`MPS_CTRL_ANALOG];
            end
            if (host_rej) begin
                rej_q <= 1'b1;
            end else if (rej_clr) begin
                rej_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // operation data out
    // ----------------------------------------------------------------
    mps_opdata_sel u_sel (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .analog_mode (analog_q),
        .speed       (ram_q[sel_base + 7'(`MPS_F_SPEED)]),
        .accel       (ram_q[sel_base + 7'(`MPS_F_ACCEL)]),
        .decel       (ram_q[sel_base + 7'(`MPS_F_DECEL)]),
        .torque      (ram_q[sel_base + 7'(`MPS_F_TORQUE)]),
        .op_speed    (op_speed),
        .op_accel    (op_accel),
        .op_decel    (op_decel),
        .op_torque   (op_torque),
        .op_ramp_ref (op_ramp_ref)
    );

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    wire mps_word_t stat_word = {13'h0000, motor_running, rej_q, !idle};
    wire mps_word_t ctrl_word = {13'h0000, analog_q, 2'h0};
    wire mps_word_t rd_mux    = in_ram  ? ram_q[ridx] :
                                in_eff  ? eff_q[addr[3:0]] :
                                is_ctrl ? ctrl_word :
                                is_stat ? stat_word :
                                is_pend ? pend_q : 16'h0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 16'h0000;
        end else if (rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign rdata = rdata_q;
endmodule // mps_param_store

//--- testbench/mps_param_store_asserts.sv
// assertions of the motor parameter store
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_param_store_asserts import mps_pkg::*; (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire mps_pkg::mps_addr_t addr,
    input wire mps_pkg::mps_word_t wdata,
    input wire logic               wr,
    input wire logic               motor_running,
    input wire logic [3:0]         op_select,
    input wire logic               internal_processing_flag,
    input wire mps_pkg::mps_word_t op_accel,
    input wire mps_pkg::mps_word_t op_torque,
    input wire logic [255:0]       param_eff,
    input wire logic [15:0]        param_pending
);
    logic       busy;
    logic       ctrl_wr;
    logic [6:0] run_q;
    assign busy = internal_processing_flag;
    assign ctrl_wr = wr && !busy && addr == `MPS_CTRL_ADDR;
    // busy run length
    always_ff @(posedge clk) begin
        run_q <= (sys_rst || !busy) ? 7'h00 : run_q + 7'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // --------------------------------
    // sequences and properties
    // --------------------------------
    sequence s_commit_req;
        ctrl_wr && wdata[`MPS_CTRL_COMMIT];
    endsequence
    sequence s_copy_80;
        busy ##79 (busy && run_q == 7'h4f) ##1 !busy;
    endsequence
    a_reset_state: assert property (
        $fell(sys_rst) |-> busy && op_accel == `MPS_DEF_RAMP && op_torque == `MPS_DEF_TRQ)
        else $error("reset state wrong");
    a_commit_copy: assert property (s_commit_req |=> s_copy_80)
        else $error("commit busy span wrong");
    a_class_a_now: assert property (
        wr && !busy && addr[7:2] == 6'h10
        |=> param_eff[16*$past(addr[1:0]) +: 16] == $past(wdata))
        else $error("class a not applied");
    a_class_b_mark: assert property (
        wr && !busy && addr[7:2] == 6'h11 |=> param_pending[{2'b01, $past(addr[1:0])}])
        else $error("class b not pending");
    a_class_b_stop: assert property (
        !busy && !wr && !motor_running && param_pending[7:4] != 4'h0
        |=> (param_pending[7:4] & $past(param_pending[7:4])) == 4'h0)
        else $error("class b not applied at stop");
    a_class_c_cfg: assert property (
        ctrl_wr && wdata[`MPS_CTRL_CONFIG] |=> param_pending[11:8] == 4'h0)
        else $error("class c not applied");
    a_class_d_keep: assert property (
        ctrl_wr || (wr && !busy && addr[7:2] == 6'h13) |=> $stable(param_eff[255:192]))
        else $error("class d applied early");
    a_opdata_now: assert property (
        wr && !busy && addr == {2'b00, op_select, `MPS_F_TORQUE} && wdata <= `MPS_TRQ_MAX
        |-> ##2 op_torque == $past(wdata, 2))
        else $error("torque limit not immediate");
endmodule // mps_param_store_asserts

bind mps_param_store mps_param_store_asserts i_chk (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
    .motor_running(motor_running), .op_select(op_select),
    .internal_processing_flag(internal_processing_flag), .op_accel(op_accel),
    .op_torque(op_torque), .param_eff(param_eff), .param_pending(param_pending));

//--- testbench/mps_master_model.sv
// serial master model: register writes, reads and commits
`timescale 1ns/100ps
`include "mps_cfg.svh"
module mps_master_model import mps_pkg::*; (
    input  wire logic          clk,
    output mps_pkg::mps_addr_t addr,
    output mps_pkg::mps_word_t wdata,
    output logic               wr,
    output logic               rd
);
    mps_word_t exp_q[$];
    int        commits;
    initial begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        commits = 0;
    end
    // --------------------------------
    // bus cycles
    // --------------------------------
    task automatic wr_reg(input mps_addr_t a, input mps_word_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    task automatic rd_reg(input mps_addr_t a, input mps_word_t e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // commits kept rare, always before power removal
    task automatic commit();
        commits++;
        wr_reg(`MPS_CTRL_ADDR, 16'h0001);
    endtask
endmodule // mps_master_model

//--- testbench/tb_motor_parameter_store.sv
// self-checking bench of the motor parameter store
`timescale 1ns/100ps
`include "mps_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb_motor_parameter_store;
    import mps_pkg::*;
    logic         clk, sys_rst, motor_running, nv_factory_init, busy, rd_seen, wr, rd;
    logic [3:0]   op_select, n;
    mps_addr_t    addr;
    mps_word_t    wdata, rdata, op_speed, op_accel, op_decel, op_torque, op_ramp_ref;
    mps_word_t    sp, ac, tq, qv;
    mps_word_t    pv [16];
    mps_word_t    eff_exp [16];
    logic [255:0] param_eff;
    logic [15:0]  param_pending;
    logic [31:0]  seed;
    int           bad_count, samples_checked;
    mps_master_model i_mst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    mps_param_store i_dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .motor_running(motor_running),
        .nv_factory_init(nv_factory_init), .op_select(op_select),
        .internal_processing_flag(busy), .op_speed(op_speed), .op_accel(op_accel),
        .op_decel(op_decel), .op_torque(op_torque), .op_ramp_ref(op_ramp_ref),
        .param_eff(param_eff), .param_pending(param_pending));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // --------------------------------
    // read monitor and helpers
    // --------------------------------
    always @(posedge clk) begin
        if (rd_seen) begin
            qv = i_mst.exp_q.pop_front();
            `CHK(rdata, qv)
        end
        rd_seen <= rd;
    end
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (busy !== 1'b0 && k < 200);
        `CHK(k < 200, 1'b1)
    endtask
    task automatic power_up();
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        wait_idle();
    endtask
    task automatic chk_eff(input mps_word_t pend);
        @(posedge clk);
        for (int p = 0; p < 16; p++) `CHK(param_eff[16*p +: 16], eff_exp[p])
        `CHK(param_pending, pend)
    endtask
    task automatic wr_params();
        for (int p = 0; p < 16; p++) begin
            pv[p] = mps_word_t'(xs());
            i_mst.wr_reg(8'(`MPS_PAR_BASE + p), pv[p]);
        end
    endtask
    task automatic take(input int lo);
        for (int p = lo; p < lo + 4; p++) eff_exp[p] = pv[p];
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        results();
    end
    // --------------------------------
    // tests
    // --------------------------------
    initial begin
        seed = 32'hec88;
        sys_rst = 1'b1;
        motor_running = 1'b0;
        nv_factory_init = 1'b1;
        op_select = 4'h0;
        rd_seen = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        nv_factory_init <= 1'b0;
        power_up();
        `CHK(op_accel, `MPS_DEF_RAMP)
        `CHK(op_torque, `MPS_DEF_TRQ)
        `CHK(op_speed, `MPS_DEF_SPEED)
        eff_exp = '{default: 16'h0000};
        chk_eff(16'h0000);
        $display("test power-up done");
        n = 4'(xs());
        op_select <= n;
        sp = 16'(80 + xs() % 3921);
        ac = 16'(2 + xs() % 149);
        tq = 16'(xs() % 201);
        i_mst.wr_reg({2'b00, n, `MPS_F_SPEED}, sp);
        i_mst.wr_reg({2'b00, n, `MPS_F_DECEL}, ac);
        i_mst.wr_reg({2'b00, n, `MPS_F_TORQUE}, tq);
        i_mst.wr_reg({2'b00, n, `MPS_F_SPEED}, `MPS_SPD_MIN_DG - 16'h0001);
        @(posedge clk);
        `CHK(op_speed, sp)
        `CHK(op_decel, ac)
        `CHK(op_torque, tq)
        `CHK(op_ramp_ref, sp)
        i_mst.rd_reg(`MPS_STAT_ADDR, 16'h0002);
        i_mst.wr_reg(`MPS_STAT_ADDR, 16'h0002);
        i_mst.wr_reg(`MPS_CTRL_ADDR, 16'h0004);
        i_mst.wr_reg({2'b00, n, `MPS_F_SPEED}, `MPS_SPD_MIN_DG);
        i_mst.rd_reg(`MPS_STAT_ADDR, 16'h0002);
        i_mst.rd_reg({2'b00, n, `MPS_F_SPEED}, sp);
        `CHK(op_ramp_ref, `MPS_RATED_SPD)
        i_mst.wr_reg(`MPS_STAT_ADDR, 16'h0002);
        i_mst.wr_reg(`MPS_CTRL_ADDR, 16'h0000);
        $display("test operation data done");
        motor_running <= 1'b1;
        wr_params();
        take(0);
        chk_eff(16'hfff0);
        motor_running <= 1'b0;
        repeat (2) @(posedge clk);
        take(4);
        chk_eff(16'hff00);
        i_mst.wr_reg(`MPS_CTRL_ADDR, 16'h0002);
        take(8);
        chk_eff(16'hf000);
        i_mst.rd_reg(`MPS_PEND_ADDR, 16'hf000);
        i_mst.rd_reg(`MPS_EFF_BASE + 8'h0c, 16'h0000);
        $display("test update classes done");
        power_up();
        eff_exp = '{default: 16'h0000};
        chk_eff(16'h0000);
        `CHK(op_accel, `MPS_DEF_RAMP)
        $display("test volatile loss done");
        wr_params();
        i_mst.commit();
        `CHK(i_mst.commits, 1)
        i_mst.wr_reg(`MPS_PAR_BASE, ~pv[0]);
        `CHK(busy, 1'b1)
        wait_idle();
        i_mst.rd_reg(`MPS_STAT_ADDR, 16'h0002);
        i_mst.rd_reg(`MPS_PAR_BASE, pv[0]);
        power_up();
        for (int p = 0; p < 16; p++) eff_exp[p] = pv[p];
        chk_eff(16'h0000);
        $display("test commit done");
        repeat (2) @(posedge clk);
        results();
    end
endmodule // tb_motor_parameter_store
